// file: rtl/hold_timer.sv
// Purpose: counts the strap hold window after power-on
// Assumes: clear_i high while the block is powered down or reset
// Notes:   done_o stays high until the next clear
`timescale 1ns/1ps
module hold_timer #(
	parameter int unsigned CYCLES = 60000
) (
	input  wire logic clk_i,
	input  wire logic clear_i,
	output logic      done_o
);

	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_done;

	// saturates on done, so one window per power-on
	always_comb begin
		next_count = count;
		next_done  = done_o;
		if (clear_i) begin
			next_count = '0;
			next_done  = 1'b0;
		end else if (!done_o) begin
			next_count = count + CW'(1);
			next_done  = (count == LAST);
		end
	end

	always_ff @(posedge clk_i) begin
		count  <= next_count;
		done_o <= next_done;
	end

endmodule

// file: rtl/strap_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock, 8-bit register byte addresses
// Notes:   definitions only
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH

// timing, figures as printed, counts derived from the clock rate
`define CLK_FREQ_HZ      20000000
`define HOLD_TIME_MS     3
`define HOLD_CYCLES      (`HOLD_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define RAIL_SETTLE_US   50
`define RESET_LOW_US     50
`define RESET_LOW_CYCLES \
	((`RESET_LOW_US * (`CLK_FREQ_HZ / 1000) + 999) / 1000)

// register byte offsets
`define REG_STATUS       8'h00
`define REG_FUSE         8'h04
`define REG_STORE        8'h08
`define REG_GPIO_CTRL    8'h0C
`define REG_GPIO_IN      8'h10

// status fields
`define ST_LATCHED       0
`define ST_STRAP_A       1
`define ST_STRAP_B       2
`define ST_STRAP_DBG     3
`define ST_BOOT_LO       4
`define ST_SER_PRINT     6
`define ST_USB_PRINT     7
`define ST_DBG_LO        8
`define ST_POWERED       10

// fuse fields
`define FU_SER_LO        0
`define FU_USB_PRINT_DIS 2
`define FU_PAD_DBG_DIS   3
`define FU_USB_DBG_DIS   4
`define FU_DBG_SEL_EN    5

// gpio control fields: [2:0] out, [5:3] drive enable, [6] usb to gpio
`define GC_OUT_LO        0
`define GC_OE_LO         3
`define GC_USB_GPIO      6

// reset values
`define FUSE_RST         6'h00
`define STORE_RST        1'h0
`define GPIO_RST         7'h00

// response codes
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: rtl/strap_latch_reset_config.sv
// Purpose: power-on gating, strap latching and boot configuration
// Assumes: AXI4-Lite slave, 8-bit byte address, one clock at 20 MHz
// Notes:   fuses and retained store clear only on RST_I
`timescale 1ns/1ps
`include "strap_defs.svh"

// How it works
// - the block runs while the power-on pin is high and is off while low.
// - each strap latch samples its pin at reset and keeps it to power-down.
// - latched straps change only by reset sampling and are always readable.
// - after reset handling the strap pins become ordinary general IO.
// - straps are read in the 3 ms hold window and only then released as IO.
// - the second boot-select strap gets a weak pull-up until the straps latch, the others no pull.
// - fuse bits read 0 unprogrammed and once set return to 0 only on RST_I.
// - boot mode, printing and debug source come from straps, fuses, store.
// - USB data pins stay on the USB controller until software moves them.
// - boot parameters are applied by hardware alone at power-up or reset.
// - second boot-select 1 gives flash boot, 0 with first at 1 download.
// - boot printing is off while store bit 0 is 1; at 0 the print fuses and, for serial, the first strap decide.
// - debug strap and debug fuses pick dedicated pins or USB for debug.
module strap_latch_reset_config #(
	parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES
) (
	input  wire logic                    CLK_SYS_I,
	input  wire logic                    RST_I,
	input  wire logic                    POWER_ON_I,
	input  wire logic                    BOOT_SELECT_STRAP_A_I,
	output logic                         BOOT_SELECT_STRAP_A_O,
	output logic                         BOOT_SELECT_STRAP_A_OE_N_O,
	input  wire logic                    BOOT_SELECT_STRAP_B_I,
	output logic                         BOOT_SELECT_STRAP_B_O,
	output logic                         BOOT_SELECT_STRAP_B_OE_N_O,
	output logic                         BOOT_SELECT_STRAP_B_PULLUP_O,
	input  wire logic                    DEBUG_SOURCE_STRAP_I,
	output logic                         DEBUG_SOURCE_STRAP_O,
	output logic                         DEBUG_SOURCE_STRAP_OE_N_O,
	output logic                         POWERED_O,
	output logic                         CORE_RESET_O,
	output logic                         STRAPS_VALID_O,
	output strap_pkg::boot_mode_type     BOOT_MODE_O,
	output logic                         SERIAL_PRINT_EN_O,
	output logic                         USB_PRINT_EN_O,
	output strap_pkg::debug_src_type     DEBUG_SOURCE_O,
	output logic                         USB_PINS_GPIO_O,
	input  wire logic [7:0]              AWADDR_I,
	input  wire logic                    AWVALID_I,
	output logic                         AWREADY_O,
	input  wire logic [31:0]             WDATA_I,
	input  wire logic [3:0]              WSTRB_I,
	input  wire logic                    WVALID_I,
	output logic                         WREADY_O,
	output logic [1:0]                   BRESP_O,
	output logic                         BVALID_O,
	input  wire logic                    BREADY_I,
	input  wire logic [7:0]              ARADDR_I,
	input  wire logic                    ARVALID_I,
	output logic                         ARREADY_O,
	output logic [31:0]                  RDATA_O,
	output logic [1:0]                   RRESP_O,
	output logic                         RVALID_O,
	input  wire logic                    RREADY_I
);
	import strap_pkg::*;

	logic [3:0]    pin_s;
	logic          pwr_rst;
	logic          hold_done;

	// config state
	logic          latched;
	logic          strap_a;
	logic          strap_b;
	logic          strap_dbg;
	logic [5:0]    fuse;
	logic          store0;
	logic [6:0]    gpio_ctrl;
	logic [2:0]    pin_out;
	logic [2:0]    pin_oe_n;
	logic          next_latched;
	logic          next_strap_a;
	logic          next_strap_b;
	logic          next_strap_dbg;
	logic [5:0]    next_fuse;
	logic          next_store0;
	logic [6:0]    next_gpio_ctrl;
	logic [2:0]    next_pin_out;
	logic [2:0]    next_pin_oe_n;
	logic          next_powered;
	logic          next_core_rst;
	logic          next_pullup;
	boot_mode_type next_boot;
	logic          next_ser;
	logic          next_usb;
	debug_src_type next_dbg;
	boot_mode_type d_boot;
	logic          d_ser;
	debug_src_type d_dbg;

	// bus state
	logic          aw_got;
	logic          w_got;
	logic [7:0]    aw_addr;
	logic [31:0]   w_data;
	logic          w_strb0;
	logic          wr_fire;
	logic          next_aw_got;
	logic          next_w_got;
	logic [7:0]    next_aw_addr;
	logic [31:0]   next_w_data;
	logic          next_w_strb0;
	logic          next_awready;
	logic          next_wready;
	logic          next_bvalid;
	logic [1:0]    next_bresp;
	logic          next_arready;
	logic          next_rvalid;
	logic [1:0]    next_rresp;
	logic [31:0]   next_rdata;

	// pins come from outside the clock domain
	sync_bank #(
		.WIDTH (4)
	) u_sync (
		.clk_i (CLK_SYS_I),
		.rst_i (RST_I),
		.d_i   ({DEBUG_SOURCE_STRAP_I, BOOT_SELECT_STRAP_B_I,
		         BOOT_SELECT_STRAP_A_I, POWER_ON_I}),
		.q_o   (pin_s)
	);

	// power-on pin low at a clock edge holds straps, pins and core down
	assign pwr_rst = RST_I | ~pin_s[0];

	hold_timer #(
		.CYCLES (HOLD_CYCLES)
	) u_hold (
		.clk_i   (CLK_SYS_I),
		.clear_i (pwr_rst),
		.done_o  (hold_done)
	);

	assign wr_fire = aw_got & w_got & ~BVALID_O;

	// boot parameters decoded from live pins, kept only at capture
	always_comb begin
		if (pin_s[2]) begin
			d_boot = BOOT_FLASH;
		end else if (pin_s[1]) begin
			d_boot = BOOT_DOWNLOAD;
		end else begin
			d_boot = BOOT_INVALID;
		end
		case (fuse[`FU_SER_LO +: 2])
			2'h0: d_ser = 1'b1;
			2'h1: d_ser = ~pin_s[1];
			2'h2: d_ser = pin_s[1];
			default: d_ser = 1'b0;
		endcase
		case ({fuse[`FU_PAD_DBG_DIS], fuse[`FU_USB_DBG_DIS]})
			2'b00: begin
				if (fuse[`FU_DBG_SEL_EN] && !pin_s[3]) begin
					d_dbg = DEBUG_PINS;
				end else begin
					d_dbg = DEBUG_USB;
				end
			end
			2'b01: d_dbg = DEBUG_PINS;
			2'b10: d_dbg = DEBUG_USB;
			default: d_dbg = DEBUG_OFF;
		endcase
	end

	// strap capture, fuse and register updates, pin release
	always_comb begin
		next_latched   = latched;
		next_strap_a   = strap_a;
		next_strap_b   = strap_b;
		next_strap_dbg = strap_dbg;
		next_fuse      = fuse;
		next_store0    = store0;
		next_gpio_ctrl = gpio_ctrl;
		next_boot      = BOOT_MODE_O;
		next_ser       = SERIAL_PRINT_EN_O;
		next_usb       = USB_PRINT_EN_O;
		next_dbg       = DEBUG_SOURCE_O;
		next_powered   = pin_s[0];
		// core held in reset through the hold window
		next_core_rst  = pwr_rst | ~hold_done;
		// capture once per power-on, pins ignored afterwards
		if (hold_done && !latched) begin
			next_latched   = 1'b1;
			next_strap_a   = pin_s[1];
			next_strap_b   = pin_s[2];
			next_strap_dbg = pin_s[3];
			next_boot      = d_boot;
			next_ser       = d_ser & ~store0;
			next_usb       = ~store0 & ~fuse[`FU_USB_PRINT_DIS];
			next_dbg       = d_dbg;
		end
		if (wr_fire && w_strb0) begin
			case (aw_addr & 8'hFC)
				`REG_FUSE: next_fuse = fuse | w_data[5:0];
				`REG_STORE: next_store0 = w_data[0];
				`REG_GPIO_CTRL: next_gpio_ctrl = w_data[6:0];
				default: next_fuse = fuse;
			endcase
		end
		// straps are not writable: no bus path reaches them
		if (pwr_rst) begin
			next_latched   = 1'b0;
			next_strap_a   = 1'b0;
			next_strap_b   = 1'b0;
			next_strap_dbg = 1'b0;
			next_gpio_ctrl = `GPIO_RST;
			next_boot      = BOOT_INVALID;
			next_ser       = 1'b0;
			next_usb       = 1'b0;
			next_dbg       = DEBUG_OFF;
		end
		// pull-up on whenever the straps are not latched, in power-down and the hold window
		next_pullup = ~next_latched;
		if (next_latched) begin
			next_pin_out  = next_gpio_ctrl[`GC_OUT_LO +: 3];
			next_pin_oe_n = ~next_gpio_ctrl[`GC_OE_LO +: 3];
		end else begin
			next_pin_out  = 3'h0;
			next_pin_oe_n = 3'h7;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			latched                      <= 1'b0;
			strap_a                      <= 1'b0;
			strap_b                      <= 1'b0;
			strap_dbg                    <= 1'b0;
			fuse                         <= `FUSE_RST;
			store0                       <= `STORE_RST;
			gpio_ctrl                    <= `GPIO_RST;
			pin_out                      <= 3'h0;
			pin_oe_n                     <= 3'h7;
			POWERED_O                    <= 1'b0;
			CORE_RESET_O                 <= 1'b1;
			BOOT_SELECT_STRAP_B_PULLUP_O <= 1'b1;
			BOOT_MODE_O                  <= BOOT_INVALID;
			SERIAL_PRINT_EN_O            <= 1'b0;
			USB_PRINT_EN_O               <= 1'b0;
			DEBUG_SOURCE_O               <= DEBUG_OFF;
		end else begin
			latched                      <= next_latched;
			strap_a                      <= next_strap_a;
			strap_b                      <= next_strap_b;
			strap_dbg                    <= next_strap_dbg;
			fuse                         <= next_fuse;
			store0                       <= next_store0;
			gpio_ctrl                    <= next_gpio_ctrl;
			pin_out                      <= next_pin_out;
			pin_oe_n                     <= next_pin_oe_n;
			POWERED_O                    <= next_powered;
			CORE_RESET_O                 <= next_core_rst;
			BOOT_SELECT_STRAP_B_PULLUP_O <= next_pullup;
			BOOT_MODE_O                  <= next_boot;
			SERIAL_PRINT_EN_O            <= next_ser;
			USB_PRINT_EN_O               <= next_usb;
			DEBUG_SOURCE_O               <= next_dbg;
		end
	end

	// pin and flag outputs are flops already
	assign BOOT_SELECT_STRAP_A_O      = pin_out[0];
	assign BOOT_SELECT_STRAP_B_O      = pin_out[1];
	assign DEBUG_SOURCE_STRAP_O       = pin_out[2];
	assign BOOT_SELECT_STRAP_A_OE_N_O = pin_oe_n[0];
	assign BOOT_SELECT_STRAP_B_OE_N_O = pin_oe_n[1];
	assign DEBUG_SOURCE_STRAP_OE_N_O  = pin_oe_n[2];
	assign STRAPS_VALID_O             = latched;
	assign USB_PINS_GPIO_O            = gpio_ctrl[`GC_USB_GPIO];

	// write path: address and data in either order, commit a cycle later
	always_comb begin
		next_aw_got  = aw_got;
		next_w_got   = w_got;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb0 = w_strb0;
		next_bvalid  = BVALID_O;
		next_bresp   = BRESP_O;
		if (AWVALID_I && AWREADY_O) begin
			next_aw_got  = 1'b1;
			next_aw_addr = AWADDR_I;
		end
		if (WVALID_I && WREADY_O) begin
			next_w_got   = 1'b1;
			next_w_data  = WDATA_I;
			next_w_strb0 = WSTRB_I[0];
		end
		if (BVALID_O && BREADY_I) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_got = 1'b0;
			next_w_got  = 1'b0;
			next_bvalid = 1'b1;
			case (aw_addr & 8'hFC)
				`REG_STATUS, `REG_FUSE, `REG_STORE,
				`REG_GPIO_CTRL, `REG_GPIO_IN: next_bresp = `RESP_OKAY;
				default: next_bresp = `RESP_SLVERR;
			endcase
		end
		// one write in flight: stall both channels until the response
		next_awready = ~next_aw_got & ~next_bvalid;
		next_wready  = ~next_w_got & ~next_bvalid;
	end

	// read path: answer one cycle after the address is taken
	always_comb begin
		next_rvalid = RVALID_O;
		next_rresp  = RRESP_O;
		next_rdata  = RDATA_O;
		if (RVALID_O && RREADY_I) begin
			next_rvalid = 1'b0;
		end
		if (ARVALID_I && ARREADY_O) begin
			next_rvalid = 1'b1;
			next_rresp  = `RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			case (ARADDR_I & 8'hFC)
				`REG_STATUS: begin
					next_rdata[`ST_LATCHED]     = latched;
					next_rdata[`ST_STRAP_A]     = strap_a;
					next_rdata[`ST_STRAP_B]     = strap_b;
					next_rdata[`ST_STRAP_DBG]   = strap_dbg;
					next_rdata[`ST_BOOT_LO +: 2] = BOOT_MODE_O;
					next_rdata[`ST_SER_PRINT]   = SERIAL_PRINT_EN_O;
					next_rdata[`ST_USB_PRINT]   = USB_PRINT_EN_O;
					next_rdata[`ST_DBG_LO +: 2] = DEBUG_SOURCE_O;
					next_rdata[`ST_POWERED]     = POWERED_O;
				end
				`REG_FUSE: next_rdata[5:0] = fuse;
				`REG_STORE: next_rdata[0] = store0;
				`REG_GPIO_CTRL: next_rdata[6:0] = gpio_ctrl;
				`REG_GPIO_IN: next_rdata[2:0] = pin_s[3:1];
				default: next_rresp = `RESP_SLVERR;
			endcase
		end
		next_arready = ~next_rvalid;
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			aw_got    <= 1'b0;
			w_got     <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0000_0000;
			w_strb0   <= 1'b0;
			AWREADY_O <= 1'b1;
			WREADY_O  <= 1'b1;
			BVALID_O  <= 1'b0;
			BRESP_O   <= `RESP_OKAY;
			ARREADY_O <= 1'b1;
			RVALID_O  <= 1'b0;
			RRESP_O   <= `RESP_OKAY;
			RDATA_O   <= 32'h0000_0000;
		end else begin
			aw_got    <= next_aw_got;
			w_got     <= next_w_got;
			aw_addr   <= next_aw_addr;
			w_data    <= next_w_data;
			w_strb0   <= next_w_strb0;
			AWREADY_O <= next_awready;
			WREADY_O  <= next_wready;
			BVALID_O  <= next_bvalid;
			BRESP_O   <= next_bresp;
			ARREADY_O <= next_arready;
			RVALID_O  <= next_rvalid;
			RRESP_O   <= next_rresp;
			RDATA_O   <= next_rdata;
		end
	end

endmodule

// file: rtl/strap_pkg.sv
// Purpose: types shared by the strap and boot configuration block
// Assumes: nothing
// Notes:   enum codes left to the tool
package strap_pkg;

	typedef enum logic [1:0] {
		BOOT_FLASH,
		BOOT_DOWNLOAD,
		BOOT_INVALID
	} boot_mode_type;

	typedef enum logic [1:0] {
		DEBUG_USB,
		DEBUG_PINS,
		DEBUG_OFF
	} debug_src_type;

endpackage

// file: rtl/sync_bank.sv
// Purpose: two flip-flop synchroniser for a bank of pin levels
// Assumes: levels only, no pulses narrower than two clocks
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module sync_bank #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	// plain shift, nothing else looks at meta
	always_comb begin
		next_meta = d_i;
		next_q    = meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= next_meta;
			q_o  <= next_q;
		end
	end

endmodule

// file: tb/board_model.sv
// Purpose: board reset circuit driving power-on and strap levels
// Assumes: supplies applied at time zero
// Notes:   released lines toggle so stale levels cannot pass
`timescale 1ns/1ps
module board_model #(
	parameter int unsigned HOLD_CYCLES   = 60000,
	parameter int unsigned SETTLE_CYCLES = 1000
) (
	input  wire logic       clk_i,
	input  wire logic       power_req_i,
	input  wire logic [2:0] strap_i,
	input  wire logic       float_b_i,
	input  wire logic [2:0] dev_out_i,
	input  wire logic [2:0] dev_oe_n_i,
	input  wire logic       pullup_b_i,
	output logic            power_on_o,
	output logic [2:0]      pin_o
);
	int unsigned cnt = 0;
	logic        drive;
	initial power_on_o = 1'b0;
	// raise only after rails settle or the low time has run
	always @(posedge clk_i) begin
		cnt <= (cnt < 32'h00FFFFFF) ? cnt + 1 : cnt;
		if (power_req_i != power_on_o &&
				(!power_req_i || cnt >= SETTLE_CYCLES)) begin
			power_on_o <= power_req_i;
			cnt <= 0;
		end
	end
	assign drive = !power_on_o || cnt < HOLD_CYCLES + 10;
	// wire level: device drive, board drive, pull-up, else noise
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (!dev_oe_n_i[i]) pin_o[i] = dev_out_i[i];
			else if (drive && !(i == 1 && float_b_i)) pin_o[i] = strap_i[i];
			else if (i == 1 && pullup_b_i) pin_o[i] = 1'b1;
			else pin_o[i] = cnt[0] ^ i[0];
		end
	end
endmodule

// file: tb/strap_chk_sva.sv
// Purpose: concurrent checks on strap latching and boot outputs
// Assumes: bound to the top module, one clock domain
// Notes:   hold count runs from the raw power-on pin
`timescale 1ns/1ps
module strap_chk #(
	parameter int unsigned HOLD_CYCLES = 60000
) (
	input wire logic                     CLK_SYS_I,
	input wire logic                     RST_I,
	input wire logic                     POWER_ON_I,
	input wire logic                     BOOT_SELECT_STRAP_A_I,
	input wire logic                     BOOT_SELECT_STRAP_B_I,
	input wire logic                     BOOT_SELECT_STRAP_A_OE_N_O,
	input wire logic                     BOOT_SELECT_STRAP_B_OE_N_O,
	input wire logic                     DEBUG_SOURCE_STRAP_OE_N_O,
	input wire logic                     BOOT_SELECT_STRAP_B_PULLUP_O,
	input wire logic                     POWERED_O,
	input wire logic                     CORE_RESET_O,
	input wire logic                     STRAPS_VALID_O,
	input wire strap_pkg::boot_mode_type BOOT_MODE_O,
	input wire logic                     USB_PINS_GPIO_O
);
	import strap_pkg::*;
	int unsigned on_cnt;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// cycles since the pin rose; saturates so long runs cannot wrap
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I || !POWER_ON_I) begin
			on_cnt <= 0;
		end else if (on_cnt < 32'h0000FFFF) begin
			on_cnt <= on_cnt + 1;
		end
	end
	AST_POWER_OFF: assert property (
		!POWER_ON_I [*5] |-> !POWERED_O && CORE_RESET_O)
		else $error("block up with power-on pin low");
	AST_POWER_ON: assert property (
		POWER_ON_I [*5] |-> POWERED_O)
		else $error("block down with power-on pin high");
	AST_HOLD_WINDOW: assert property (
		$rose(STRAPS_VALID_O) |->
		on_cnt >= HOLD_CYCLES && on_cnt <= HOLD_CYCLES + 8)
		else $error("straps latched outside the hold window");
	AST_HOLD_DONE: assert property (
		on_cnt == HOLD_CYCLES + 10 |-> STRAPS_VALID_O)
		else $error("straps not latched after the hold window");
	AST_FROZEN: assert property (
		STRAPS_VALID_O && $past(STRAPS_VALID_O) |-> $stable(BOOT_MODE_O))
		else $error("boot mode moved while latched");
	AST_NO_DRIVE: assert property (
		!STRAPS_VALID_O && !$past(STRAPS_VALID_O) |->
		BOOT_SELECT_STRAP_A_OE_N_O && BOOT_SELECT_STRAP_B_OE_N_O &&
		DEBUG_SOURCE_STRAP_OE_N_O)
		else $error("strap pin driven before latching");
	AST_PULLUP: assert property (
		!STRAPS_VALID_O && !$past(STRAPS_VALID_O) |->
		BOOT_SELECT_STRAP_B_PULLUP_O)
		else $error("pull-up off while straps unlatched");
	AST_CORE_RUN: assert property (
		STRAPS_VALID_O |-> !CORE_RESET_O)
		else $error("core held in reset after latching");
	AST_BOOT_MODE: assert property (
		$rose(STRAPS_VALID_O) |-> BOOT_MODE_O ==
		($past(BOOT_SELECT_STRAP_B_I, 3) ? BOOT_FLASH :
		$past(BOOT_SELECT_STRAP_A_I, 3) ? BOOT_DOWNLOAD : BOOT_INVALID))
		else $error("boot mode does not follow the straps");
	AST_USB_DEFAULT: assert property (
		$rose(STRAPS_VALID_O) |-> !USB_PINS_GPIO_O)
		else $error("usb pins not on the usb controller");
endmodule

bind strap_latch_reset_config strap_chk #(
	.HOLD_CYCLES(HOLD_CYCLES)
) u_strap_chk (
	.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .POWER_ON_I(POWER_ON_I),
	.BOOT_SELECT_STRAP_A_I(BOOT_SELECT_STRAP_A_I),
	.BOOT_SELECT_STRAP_B_I(BOOT_SELECT_STRAP_B_I),
	.BOOT_SELECT_STRAP_A_OE_N_O(BOOT_SELECT_STRAP_A_OE_N_O),
	.BOOT_SELECT_STRAP_B_OE_N_O(BOOT_SELECT_STRAP_B_OE_N_O),
	.DEBUG_SOURCE_STRAP_OE_N_O(DEBUG_SOURCE_STRAP_OE_N_O),
	.BOOT_SELECT_STRAP_B_PULLUP_O(BOOT_SELECT_STRAP_B_PULLUP_O),
	.POWERED_O(POWERED_O), .CORE_RESET_O(CORE_RESET_O),
	.STRAPS_VALID_O(STRAPS_VALID_O), .BOOT_MODE_O(BOOT_MODE_O),
	.USB_PINS_GPIO_O(USB_PINS_GPIO_O)
);

// file: tb/tb_strap_latch_reset_config.sv
// Purpose: power cycles over strap and fuse settings, bus checks
// Assumes: hold window shortened to 20 cycles
// Notes:   fuses only accumulate, so cases run in fuse order
`timescale 1ns/1ps
`include "strap_defs.svh"
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb_strap_latch_reset_config;
	import strap_pkg::*;
	localparam int unsigned HOLD = 20;
	// per case: a, b, debug strap, b floating, store bit
	localparam logic [4:0] CFG [5] = '{5'h10, 5'h1A, 5'h05, 5'h08, 5'h10};
	localparam logic [5:0] FADD [5] = '{6'h00, 6'h22, 6'h01, 6'h10, 6'h0C};
	logic        clk = 1'b0, rst = 1'b1, pwr_req = 1'b0, flt = 1'b0;
	logic [2:0]  strap = 3'h0, pin, dout, doe_n;
	logic        pwr, pull, powered, core_rst, valid, ser, usb, usb_gpio;
	boot_mode_type boot;
	debug_src_type dbg;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          mismatches = 0, n_compared = 0;
	always #25 clk = ~clk;
	strap_latch_reset_config #(.HOLD_CYCLES(HOLD)) u_strap_latch_reset_config (
		.CLK_SYS_I(clk), .RST_I(rst), .POWER_ON_I(pwr),
		.BOOT_SELECT_STRAP_A_I(pin[0]), .BOOT_SELECT_STRAP_A_O(dout[0]),
		.BOOT_SELECT_STRAP_A_OE_N_O(doe_n[0]),
		.BOOT_SELECT_STRAP_B_I(pin[1]), .BOOT_SELECT_STRAP_B_O(dout[1]),
		.BOOT_SELECT_STRAP_B_OE_N_O(doe_n[1]),
		.BOOT_SELECT_STRAP_B_PULLUP_O(pull),
		.DEBUG_SOURCE_STRAP_I(pin[2]), .DEBUG_SOURCE_STRAP_O(dout[2]),
		.DEBUG_SOURCE_STRAP_OE_N_O(doe_n[2]),
		.POWERED_O(powered), .CORE_RESET_O(core_rst), .STRAPS_VALID_O(valid),
		.BOOT_MODE_O(boot), .SERIAL_PRINT_EN_O(ser), .USB_PRINT_EN_O(usb),
		.DEBUG_SOURCE_O(dbg), .USB_PINS_GPIO_O(usb_gpio),
		.AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
		.BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready)
	);
	board_model #(.HOLD_CYCLES(HOLD)) u_board_model (
		.clk_i(clk), .power_req_i(pwr_req), .strap_i(strap),
		.float_b_i(flt), .dev_out_i(dout), .dev_oe_n_i(doe_n),
		.pullup_b_i(pull), .power_on_o(pwr), .pin_o(pin)
	);
	// one write; each channel drops valid once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// no cycle count assumed: bvalid ends this wait, else the watchdog
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	// one read
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard, well past five power cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
	// main sequence
	initial begin
		logic [31:0] d, st;
		logic [1:0] r;
		logic [5:0] f;
		logic a, b, g, es, eu;
		boot_mode_type eb;
		debug_src_type ed;
		int n;
		f = 6'h00;
		repeat (19) @(posedge clk);
		`CHK(core_rst, 1'b1)
		`CHK(powered, 1'b0)
		@(posedge clk);
		rst <= 1'b0;
		rd(`REG_FUSE, d, r);
		`CHK(d, 32'h0)
		for (int k = 0; k < 5; k++) begin
			pwr_req <= 1'b0;
			for (n = 0; n < 20 && powered !== 1'b0; n++) @(posedge clk);
			`CHK({powered, valid, doe_n}, 5'h07)
			{a, b, g} = CFG[k][4:2];
			f = f | FADD[k];
			wr(`REG_FUSE, {26'h0, FADD[k]}, r);
			rd(`REG_FUSE, d, r);
			`CHK(d, {26'h0, f})
			wr(`REG_STORE, {31'h0, CFG[k][0]}, r);
			strap <= {g, b, a};
			flt <= CFG[k][1];
			pwr_req <= 1'b1;
			for (n = 0; n < 1200 && pwr !== 1'b1; n++) @(posedge clk);
			for (n = 0; n < 200 && valid !== 1'b1; n++) @(posedge clk);
			`CHK(n >= HOLD && n <= HOLD + 8, 1'b1)
			eb = b ? BOOT_FLASH : a ? BOOT_DOWNLOAD : BOOT_INVALID;
			es = !CFG[k][0] && (f[1:0] == 2'h0 ||
				(f[1:0] == 2'h1 && !a) || (f[1:0] == 2'h2 && a));
			eu = !CFG[k][0] && !f[2];
			case ({f[3], f[4]})
				2'h0: ed = (f[5] && !g) ? DEBUG_PINS : DEBUG_USB;
				2'h1: ed = DEBUG_PINS;
				2'h2: ed = DEBUG_USB;
				default: ed = DEBUG_OFF;
			endcase
			`CHK(boot, eb)
			`CHK({ser, usb}, {es, eu})
			`CHK(dbg, ed)
			`CHK({usb_gpio, core_rst}, 2'h0)
			st = {21'h0, 1'b1, ed, eu, es, eb, g, b, a, 1'b1};
			rd(`REG_STATUS, d, r);
			`CHK(d, st)
			if (k == 0) begin
				wr(`REG_GPIO_CTRL, 32'h7F, r);
				wr(`REG_STATUS, 32'h0, r);
				`CHK(r, `RESP_OKAY)
				rd(`REG_STATUS, d, r);
				`CHK(d, st)
				`CHK({doe_n, dout, usb_gpio}, 7'h0F)
				rd(`REG_GPIO_IN, d, r);
				`CHK({r, d}, {`RESP_OKAY, 32'h7})
				rd(8'h40, d, r);
				`CHK({r, d}, {`RESP_SLVERR, 32'h0})
				wr(8'h40, 32'h1, r);
				`CHK(r, `RESP_SLVERR)
			end
			// pins now released or driven away from their strap levels
			repeat (30) @(posedge clk);
			rd(`REG_STATUS, d, r);
			`CHK(d, st)
		end
		close_out();
	end
endmodule
